// ==== hw/psclg_pkg.sv ====
`default_nettype none

package psclg_pkg;

  // ----------------------------------------
  // Address map, byte offsets in the region
  // ----------------------------------------
  localparam logic [31:0] PSCLG_REGION_BASE = 32'h400fe000;
  localparam logic [11:0] PSCLG_OFS_RUN_CFG = 12'h060;
  localparam logic [11:0] PSCLG_OFS_RUN_GATE = 12'h108;
  localparam logic [11:0] PSCLG_OFS_SLEEP_GATE = 12'h118;
  localparam logic [11:0] PSCLG_OFS_DEEP_GATE = 12'h128;
  localparam logic [11:0] PSCLG_OFS_FAULT_STAT = 12'h140;
  localparam logic [11:0] PSCLG_OFS_FAULT_MASK = 12'h144;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int unsigned PSCLG_NUM_PORTS = 8;
  localparam int unsigned PSCLG_PORT_A_BIT = 0;
  localparam int unsigned PSCLG_PORT_H_BIT = 7;
  localparam int unsigned PSCLG_ACG_BIT = 27;
  localparam logic [31:0] PSCLG_RST_GATE = 32'h00000000;
  localparam logic [7:0] PSCLG_RST_GATE8 = 8'h00;
  localparam logic [31:0] PSCLG_RST_CFG = 32'h00000000;
  localparam logic [31:0] PSCLG_RD_ZERO = 32'h00000000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PSCLG_PWR_RUN = 2'b00,
    PSCLG_PWR_SLEEP = 2'b01,
    PSCLG_PWR_DEEP = 2'b10
  } psclg_pwr_t;

  typedef struct packed {
    logic hit;
    logic we;
    logic [11:0] ofs;
    logic [3:0] sel;
    logic [31:0] dat;
  } psclg_req_t;

endpackage : psclg_pkg

`default_nettype wire

// ==== hw/psclg_clk_gate.sv ====
`default_nettype none

// ----------------------------------------
// Glitch-free clock gate cell
// ----------------------------------------
module psclg_clk_gate
  import psclg_pkg::*;
(
  input wire logic clk_i, // Source clock
  input wire logic en_i, // Clock enable, registered upstream
  output logic clk_o // Gated clock
);

  logic en_lat;

  // Latch open while clock is low, so enable changes never chop a pulse
  always_latch
  begin
    if (!clk_i)
    begin
      en_lat <= en_i;
    end
  end

  assign clk_o = clk_i & en_lat;

endmodule : psclg_clk_gate

`default_nettype wire

// ==== hw/psclg_top.sv ====
// How it works
// - Eight gate bits; bit 7 is port H down to bit 0 port A.
// - A set gate bit clocks its port; a clear bit leaves it unclocked.
// - Access to a port whose clock is off gets a bus fault, not completion.
// - Reset clears the whole register, so all ports start unclocked.
// - Bits 31:8 read zero and ignore writes.
// - Sleep pattern applies only in Sleep; run and deep-sleep have own registers.
// - Sleep-mode registers are used only when auto gating select is set.
// - The register decodes at offset 0x118 in the system-control region.
//
// Implementation choice: the Wishbone register port.
`default_nettype none

module psclg_top
  import psclg_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = PSCLG_REGION_BASE
)
(
  input wire logic clk_i, // System clock, 25 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [31:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  output logic wb_err_o, // Wishbone error, unmapped address
  input wire logic sleep_i, // Core is in Sleep
  input wire logic deep_sleep_i, // Core is in Deep-Sleep
  input wire logic [7:0] port_req_i, // Access attempt per port
  output logic [7:0] port_grant_o, // Access may complete
  output logic [7:0] port_fault_o, // Access ends in bus fault
  output logic [7:0] port_clk_en_o, // Applied clock enable per port
  output logic [7:0] port_clk_o, // Gated clock per port
  output logic irq_o // Unmasked fault status pending
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] merge8(
    input logic [7:0] old_v,
    input logic [7:0] new_v,
    input logic lane_en
  );
    merge8 = lane_en ? new_v : old_v;
  endfunction : merge8

  function automatic logic ofs_is(
    input logic [11:0] a,
    input logic [11:0] b
  );
    ofs_is = (a[11:2] == b[11:2]);
  endfunction : ofs_is

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] run_port_clock_gate_r;
  logic [7:0] run_port_clock_gate_nxt;
  logic [7:0] sleep_port_clock_gate_r;
  logic [7:0] sleep_port_clock_gate_nxt;
  logic [7:0] deep_sleep_port_clock_gate_r;
  logic [7:0] deep_sleep_port_clock_gate_nxt;
  logic auto_clock_gating_select_r;
  logic auto_clock_gating_select_nxt;
  logic [7:0] fault_stat_r;
  logic [7:0] fault_stat_nxt;
  logic [7:0] fault_mask_r;
  logic [7:0] fault_mask_nxt;
  logic [7:0] clk_en_r;
  logic [7:0] clk_en_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic ack_r;
  logic err_r;
  logic irq_r;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  psclg_req_t req;
  wire region_hit = (wb_adr_i[31:12] == BASE_ADDR[31:12]);
  wire bus_take = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;

  // One driver for the whole carrier: hit, we, ofs, sel, dat
  assign req = {region_hit, wb_we_i, wb_adr_i[11:0], wb_sel_i, wb_dat_i};

  wire sel_run = req.hit & ofs_is(req.ofs, PSCLG_OFS_RUN_GATE);
  wire sel_sleep = req.hit & ofs_is(req.ofs, PSCLG_OFS_SLEEP_GATE);
  wire sel_deep = req.hit & ofs_is(req.ofs, PSCLG_OFS_DEEP_GATE);
  wire sel_cfg = req.hit & ofs_is(req.ofs, PSCLG_OFS_RUN_CFG);
  wire sel_stat = req.hit & ofs_is(req.ofs, PSCLG_OFS_FAULT_STAT);
  wire sel_mask = req.hit & ofs_is(req.ofs, PSCLG_OFS_FAULT_MASK);
  wire mapped = sel_run | sel_sleep | sel_deep | sel_cfg | sel_stat | sel_mask;
  wire wr_go = bus_take & req.we & mapped;
  wire rd_go = bus_take & ~req.we & mapped;
  wire lane0 = req.sel[0];
  wire lane3 = req.sel[3];

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // upper bits dropped
  assign run_port_clock_gate_nxt = (wr_go & sel_run)
    ? merge8(run_port_clock_gate_r, req.dat[7:0], lane0) : run_port_clock_gate_r;
  assign sleep_port_clock_gate_nxt = (wr_go & sel_sleep)
    ? merge8(sleep_port_clock_gate_r, req.dat[7:0], lane0) : sleep_port_clock_gate_r;
  assign deep_sleep_port_clock_gate_nxt = (wr_go & sel_deep)
    ? merge8(deep_sleep_port_clock_gate_r, req.dat[7:0], lane0)
    : deep_sleep_port_clock_gate_r;
  assign auto_clock_gating_select_nxt = (wr_go & sel_cfg & lane3)
    ? req.dat[PSCLG_ACG_BIT] : auto_clock_gating_select_r;
  assign fault_mask_nxt = (wr_go & sel_mask)
    ? merge8(fault_mask_r, req.dat[7:0], lane0) : fault_mask_r;

  // ----------------------------------------
  // Gating selection
  // ----------------------------------------
  psclg_pwr_t pwr;
  assign pwr = deep_sleep_i ? PSCLG_PWR_DEEP
    : (sleep_i ? PSCLG_PWR_SLEEP : PSCLG_PWR_RUN);

  logic [7:0] mode_gate;
  always_comb
  begin
    if (!auto_clock_gating_select_r)
    begin
      mode_gate = run_port_clock_gate_r;
    end
    else
    begin
      case (pwr)
        PSCLG_PWR_SLEEP: mode_gate = sleep_port_clock_gate_r;
        PSCLG_PWR_DEEP: mode_gate = deep_sleep_port_clock_gate_r;
        PSCLG_PWR_RUN: mode_gate = run_port_clock_gate_r;
        default: mode_gate = run_port_clock_gate_r;
      endcase
    end
  end

  // Registered so the gate cells see a clean, glitch-free enable
  assign clk_en_nxt = mode_gate;

  // ----------------------------------------
  // Port access check
  // ----------------------------------------
  // fault when unclocked
  assign port_fault_o = port_req_i & ~clk_en_r;
  assign port_grant_o = port_req_i & clk_en_r;

  // Set wins over a same-cycle clear so no fault is lost
  wire [7:0] stat_clr = (wr_go & sel_stat & lane0) ? req.dat[7:0] : 8'h00;
  assign fault_stat_nxt = (fault_stat_r & ~stat_clr) | port_fault_o;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = PSCLG_RD_ZERO;
    if (sel_run)
    begin
      rd_mux[7:0] = run_port_clock_gate_r;
    end
    else if (sel_sleep)
    begin
      rd_mux[7:0] = sleep_port_clock_gate_r;
    end
    else if (sel_deep)
    begin
      rd_mux[7:0] = deep_sleep_port_clock_gate_r;
    end
    else if (sel_cfg)
    begin
      rd_mux[PSCLG_ACG_BIT] = auto_clock_gating_select_r;
    end
    else if (sel_stat)
    begin
      rd_mux[7:0] = fault_stat_r;
    end
    else if (sel_mask)
    begin
      rd_mux[7:0] = fault_mask_r;
    end
  end

  assign rdata_nxt = rd_go ? rd_mux : rdata_r;

  // ----------------------------------------
  // Flops
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_port_clock_gate_r <= PSCLG_RST_GATE8;
      sleep_port_clock_gate_r <= PSCLG_RST_GATE8;
      deep_sleep_port_clock_gate_r <= PSCLG_RST_GATE8;
      auto_clock_gating_select_r <= PSCLG_RST_CFG[PSCLG_ACG_BIT];
      fault_stat_r <= PSCLG_RST_GATE8;
      fault_mask_r <= PSCLG_RST_GATE8;
      clk_en_r <= PSCLG_RST_GATE8;
      rdata_r <= PSCLG_RST_GATE;
    end
    else
    begin
      run_port_clock_gate_r <= run_port_clock_gate_nxt;
      sleep_port_clock_gate_r <= sleep_port_clock_gate_nxt;
      deep_sleep_port_clock_gate_r <= deep_sleep_port_clock_gate_nxt;
      auto_clock_gating_select_r <= auto_clock_gating_select_nxt;
      fault_stat_r <= fault_stat_nxt;
      fault_mask_r <= fault_mask_nxt;
      clk_en_r <= clk_en_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      ack_r <= bus_take & mapped;
      err_r <= bus_take & ~mapped;
      irq_r <= |(fault_stat_nxt & fault_mask_nxt);
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign wb_dat_o = rdata_r;
  assign irq_o = irq_r;
  assign port_clk_en_o = clk_en_r;

  // ----------------------------------------
  // Clock gates, one per port
  // ----------------------------------------
  // bit to port
  for (genvar p = PSCLG_PORT_A_BIT; p <= PSCLG_PORT_H_BIT; p++)
  begin : g_gate
    psclg_clk_gate u_gate (
      .clk_i(clk_i),
      .en_i(clk_en_r[p]),
      .clk_o(port_clk_o[p])
    );
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_reset_clear: assert property (
    $past(rst_i) |-> (sleep_port_clock_gate_r == 8'h00 && port_clk_en_o == 8'h00)
  ) else $error("gate state not clear after reset");

  chk_upper_zero: assert property (
    (bus_take && !wb_we_i && sel_sleep) |=> (wb_ack_o && wb_dat_o[31:8] == 24'h000000)
  ) else $error("reserved bits of sleep gate read nonzero");

  chk_write_lands: assert property (
    (bus_take && wb_we_i && sel_sleep && wb_sel_i[0])
      |=> (wb_ack_o && sleep_port_clock_gate_r == $past(wb_dat_i[7:0]))
  ) else $error("write to sleep gate did not land");

  chk_sleep_pattern: assert property (
    (auto_clock_gating_select_r && sleep_i && !deep_sleep_i)
      |=> (port_clk_en_o == $past(sleep_port_clock_gate_r))
  ) else $error("sleep pattern not applied in Sleep");

  chk_deep_pattern: assert property (
    (auto_clock_gating_select_r && deep_sleep_i)
      |=> (port_clk_en_o == $past(deep_sleep_port_clock_gate_r))
  ) else $error("deep-sleep pattern not applied");

  chk_acg_off_run: assert property (
    (!auto_clock_gating_select_r) |=> (port_clk_en_o == $past(run_port_clock_gate_r))
  ) else $error("run pattern not kept with auto select clear");

  chk_acg_gates_sleep: assert property (
    (!auto_clock_gating_select_r && sleep_i && sleep_port_clock_gate_r != run_port_clock_gate_r)
      |=> (port_clk_en_o != $past(sleep_port_clock_gate_r))
  ) else $error("sleep register used without auto select");

  chk_port_order: assert property (
    (auto_clock_gating_select_r && sleep_i && !deep_sleep_i)
      |=> (port_clk_en_o[7] == $past(sleep_port_clock_gate_r[7])
        && port_clk_en_o[0] == $past(sleep_port_clock_gate_r[0]))
  ) else $error("port H or A bound to wrong bit");

  chk_fault_unclocked: assert property (
    (port_req_i != 8'h00) |-> ((port_fault_o & port_clk_en_o) == 8'h00
      && (port_fault_o | port_grant_o) == port_req_i)
  ) else $error("gated port access not faulted");

  chk_fault_sticky: assert property (
    (port_fault_o != 8'h00) |=> ((fault_stat_r & $past(port_fault_o)) == $past(port_fault_o))
  ) else $error("fault event not recorded");

  chk_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o
  ) else $error("ack held longer than one cycle");

  chk_err_pulse: assert property (
    (bus_take && !mapped) |=> (wb_err_o && !wb_ack_o)
  ) else $error("unmapped access not answered with error");

  chk_run_mode: assert property (
    (!sleep_i && !deep_sleep_i) |=> (port_clk_en_o == $past(run_port_clock_gate_r))
  ) else $error("run pattern not applied while running");

  chk_stat_clear: assert property (
    (wr_go && sel_stat && lane0 && port_fault_o == 8'h00)
      |=> ((fault_stat_r & $past(wb_dat_i[7:0])) == 8'h00)
  ) else $error("fault status bit not cleared by writing one");

  chk_irq_level: assert property (
    irq_o == |(fault_stat_r & fault_mask_r)
  ) else $error("interrupt level differs from masked status");

  chk_grant_clocked: assert property (
    (port_grant_o & ~port_clk_en_o) == 8'h00
  ) else $error("access granted to an unclocked port");

endmodule : psclg_top

`default_nettype wire

// ==== verif/psclg_port_model.sv ====
`default_nettype none

// ----
// Software touching the eight ports
// ----
module psclg_port_model
  import psclg_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [7:0] want_i, // Ports software will touch
  output logic [7:0] req_o // Access attempt per port
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      req_o <= 8'h00;
    else
      req_o <= want_i;
  end
endmodule : psclg_port_model

`default_nettype wire

// ==== verif/tb.sv ====
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import psclg_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = 32'h0;
  logic sleep = 1'b0;
  logic deep = 1'b0;
  logic [7:0] want = 8'h00;
  logic [7:0] preq;
  wire [31:0] rdat;
  wire ack, err, irq;
  wire [7:0] grant, fault, en;
  wire [7:0] pclk;
  logic [33:0] exp_q[$];
  logic [33:0] note;
  logic [31:0] s = 32'h27e2;
  logic [7:0] x;
  int err_total = 0;
  int n_tests = 0;
  int i, a, m;

  always #20 clk_i = ~clk_i;

  psclg_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .sleep_i(sleep), .deep_sleep_i(deep),
    .port_req_i(preq), .port_grant_o(grant), .port_fault_o(fault),
    .port_clk_en_o(en), .port_clk_o(pclk), .irq_o(irq));

  psclg_port_model u_sw (.clk_i(clk_i), .rst_i(rst_i), .want_i(want), .req_o(preq));

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] e);
    n_tests++;
    if (seen !== e)
    begin
      err_total++;
      $display("mismatch %s exp %h seen %h", name, e, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // Classic cycle, held until ack or err is sampled
  task automatic wb(input logic w, input logic [11:0] ofs, input logic [31:0] d,
    input logic rchk, input logic e, input logic [31:0] xv);
    int n;
    exp_q.push_back({rchk, e, xv});
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= PSCLG_REGION_BASE | {20'h0, ofs};
    dat <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (!(ack === 1'b1 || err === 1'b1) && n < 50);
    if (n == 50)
      check("wb_wait", 32'h0, 32'h1);
    req <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
    wb(1'b1, ofs, d, 1'b0, 1'b0, 32'h0);
  endtask : wr

  task automatic rd(input logic [11:0] ofs, input logic [31:0] xv);
    wb(1'b0, ofs, 32'h0, 1'b1, 1'b0, xv);
  endtask : rd

  task automatic settle;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  task automatic mode(input logic sl, input logic dp);
    @(posedge clk_i);
    sleep <= sl;
    deep <= dp;
    settle();
  endtask : mode

  // ----
  // Answer monitor
  // ----
  always @(posedge clk_i)
  begin
    if (ack === 1'b1 || err === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("wb_extra", 32'h1, 32'h0);
      else
      begin
        note = exp_q.pop_front();
        check("wb_err", {31'h0, err}, {31'h0, note[32]});
        if (note[33])
          check("wb_dat", rdat, note[31:0]);
      end
    end
  end

  // ----
  // Scenarios
  // ----
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check("en_rst", {24'h0, en}, 32'h0);
    rd(PSCLG_OFS_SLEEP_GATE, PSCLG_RST_GATE);
    rd(PSCLG_OFS_RUN_GATE, 32'h0);
    wb(1'b0, 12'h11c, 32'h0, 1'b0, 1'b1, 32'h0);
    wr(PSCLG_OFS_SLEEP_GATE, 32'hffffffff);
    rd(PSCLG_OFS_SLEEP_GATE, 32'h000000ff);
    // Read-modify-write hands the reserved bits back as read
    wr(PSCLG_OFS_SLEEP_GATE, 32'h000000ff & ~32'h00000001);
    rd(PSCLG_OFS_SLEEP_GATE, 32'h000000fe);
    // Lane 0 off: gate bits must hold
    @(posedge clk_i);
    sel <= 4'he;
    wr(PSCLG_OFS_SLEEP_GATE, 32'h0);
    rd(PSCLG_OFS_SLEEP_GATE, 32'h000000fe);
    @(posedge clk_i);
    sel <= 4'hf;
    wr(PSCLG_OFS_RUN_CFG, 32'h1 << PSCLG_ACG_BIT);
    mode(1'b1, 1'b0);
    for (i = 0; i < 8; i++)
    begin
      wr(PSCLG_OFS_SLEEP_GATE, 32'h1 << i);
      settle();
      check("en_walk", {24'h0, en}, 32'h1 << i);
      check("pclk_low", {24'h0, pclk}, 32'h0);
      @(posedge clk_i);
      #2;
      check("pclk_walk", {24'h0, pclk}, 32'h1 << i);
    end
    for (i = 0; i < 4; i++)
    begin
      s = lfsr(lfsr(s));
      wr(PSCLG_OFS_RUN_GATE, {s[31:8], s[7:0]});
      wr(PSCLG_OFS_SLEEP_GATE, {s[7:0], s[31:8]});
      wr(PSCLG_OFS_DEEP_GATE, {s[23:0], s[31:24]});
      rd(PSCLG_OFS_DEEP_GATE, {24'h0, s[31:24]});
      for (a = 0; a < 2; a++)
      begin
        wr(PSCLG_OFS_RUN_CFG, a[0] ? 32'h1 << PSCLG_ACG_BIT : 32'h0);
        for (m = 0; m < 3; m++)
        begin
          mode(m == 1, m == 2);
          x = (a == 0 || m == 0) ? s[7:0] : (m == 1 ? s[15:8] : s[31:24]);
          check("en_mode", {24'h0, en}, {24'h0, x});
        end
      end
    end
    // Faults and interrupt with run pattern 5a
    mode(1'b0, 1'b0);
    wr(PSCLG_OFS_RUN_GATE, 32'h5a);
    @(posedge clk_i);
    want <= 8'hff;
    settle();
    check("fault", {24'h0, fault}, 32'ha5);
    check("grant", {24'h0, grant}, 32'h5a);
    check("irq_masked", {31'h0, irq}, 32'h0);
    @(posedge clk_i);
    want <= 8'h00;
    wr(PSCLG_OFS_FAULT_MASK, 32'hff);
    settle();
    check("irq_on", {31'h0, irq}, 32'h1);
    rd(PSCLG_OFS_FAULT_STAT, 32'ha5);
    wr(PSCLG_OFS_FAULT_STAT, 32'hff);
    settle();
    check("irq_off", {31'h0, irq}, 32'h0);
    rd(PSCLG_OFS_FAULT_STAT, 32'h0);
    // Reset again in mid-run: the run pattern 5a must clear
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check("en_rst2", {24'h0, en}, 32'h0);
    rd(PSCLG_OFS_RUN_GATE, 32'h0);
    check("queue", exp_q.size(), 32'h0);
    finish_test();
  end

  initial
  begin
    #(40 * 20000);
    err_total++;
    finish_test();
  end
endmodule : tb

`default_nettype wire
